//--- core/timer_pwm_pkg.sv
// constants shared by the dual 8-bit timer block
package timer_pwm_pkg;
    // ---------------------------------------------------------------
    // register map (byte addresses, one word per register)
    // ---------------------------------------------------------------
    localparam logic [7:0] CHAN_STRIDE   = 8'h10;
    localparam logic [7:0] OFF_MODE      = 8'h00;
    localparam logic [7:0] OFF_CLKSEL    = 8'h04;
    localparam logic [7:0] OFF_COMPARE   = 8'h08;
    localparam logic [7:0] OFF_COUNT     = 8'h0C;
    localparam logic [7:0] MAP_LAST      = 8'h1C;
    localparam int         ADDR_W        = 8;

    // ---------------------------------------------------------------
    // mode control register fields
    // ---------------------------------------------------------------
    localparam int MODE_CE_BIT      = 7;
    localparam int MODE_PWM_BIT     = 6;
    localparam int MODE_CASC_BIT    = 4;
    localparam int MODE_SET_BIT     = 3;
    localparam int MODE_RESET_BIT   = 2;
    localparam int MODE_LEVEL_BIT   = 1;
    localparam int MODE_OE_BIT      = 0;
    localparam logic [7:0] MODE_RESET_VAL = 8'h00;
    // bits kept by the lower timer and by the upper timer
    localparam logic [7:0] MODE_MASK_LOWER = 8'hC3;
    localparam logic [7:0] MODE_MASK_UPPER = 8'hD3;

    // ---------------------------------------------------------------
    // clock select and counter
    // ---------------------------------------------------------------
    localparam int         CLKSEL_W       = 3;
    localparam logic [2:0] CLKSEL_RESET   = 3'h0;
    localparam int         PRESC_W        = 10;
    localparam int         PRESC_SHIFT0   = 3;
    localparam int         CNT_W          = 8;
    localparam logic [7:0] CNT_ZERO       = 8'h00;
    localparam logic [7:0] CNT_MAX        = 8'hFF;
    localparam logic [7:0] COMPARE_RESET  = 8'h00;
endpackage

//--- core/timer_prescaler.sv
// count clock prescaler: one-cycle tick every 2**(sel+3) clocks
`timescale 1ns/1ps
`default_nettype none
module timer_prescaler (
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       run,
    input  wire logic [2:0] sel,
    output logic            tick
);
    logic [timer_pwm_pkg::PRESC_W-1:0] div_q;
    logic [timer_pwm_pkg::PRESC_W-1:0] div_d;
    logic [timer_pwm_pkg::PRESC_W-1:0] mask;
    logic [3:0]                        shiftAmt;

    assign shiftAmt = {1'b0, sel} + 4'(timer_pwm_pkg::PRESC_SHIFT0);
    assign mask     = ~({timer_pwm_pkg::PRESC_W{1'b1}} << shiftAmt);
    // stopped prescaler is held at zero
    assign div_d    = run ? div_q + 1'b1 : '0;
    assign tick     = run && ((div_q & mask) == mask);

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            div_q <= '0;
        end else begin
            div_q <= div_d;
        end
    end
endmodule
`default_nettype wire

//--- core/timer_pwm_cascade.sv
// dual 8-bit timer with PWM output and 16-bit cascade, APB slave
//
// Added by the designer: register access over APB and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module timer_pwm_cascade (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    output logic [1:0]       timerOutputPin,
    output logic [1:0]       timerOutputEn,
    output logic             lowerMatchIrq,
    output logic             upperMatchIrq
);
    // ---------------------------------------------------------------
    // address decode
    // ---------------------------------------------------------------
    // true when addr hits register offset off of channel ch
    function automatic logic hitReg(input logic [7:0] addr, input logic ch,
                                    input logic [7:0] off);
        hitReg = (addr == (off + (ch ? timer_pwm_pkg::CHAN_STRIDE : 8'h00)));
    endfunction

    logic [7:0] modeControlReg_q   [2];
    logic [2:0] countClockSelReg_q [2];
    logic [7:0] compareValueReg_q  [2];
    logic [7:0] compareActive_q    [2];
    logic [7:0] eightBitCounter_q  [2];
    logic [7:0] eightBitCounter_d  [2];
    logic [1:0] pwmLevel_q;
    logic [1:0] outFlop_q;
    logic [31:0] prdata_q;
    logic        pready_q;
    logic        pslverr_q;
    logic [1:0]  pinOut_q;
    logic [1:0]  pinEn_q;
    logic        lowerIrq_q;
    logic        upperIrq_q;

    wire setupPhase  = psel && !penable;
    wire accessDone  = psel && penable && pready_q;
    wire wrDone      = accessDone && pwrite;
    wire addrMapped  = (paddr[1:0] == 2'b00) && (paddr <= timer_pwm_pkg::MAP_LAST);

    wire [1:0] wrMode;
    wire [1:0] wrClkSel;
    wire [1:0] wrCompare;
    assign wrMode[0]    = wrDone && hitReg(paddr, 1'b0, timer_pwm_pkg::OFF_MODE);
    assign wrMode[1]    = wrDone && hitReg(paddr, 1'b1, timer_pwm_pkg::OFF_MODE);
    assign wrClkSel[0]  = wrDone && hitReg(paddr, 1'b0, timer_pwm_pkg::OFF_CLKSEL);
    assign wrClkSel[1]  = wrDone && hitReg(paddr, 1'b1, timer_pwm_pkg::OFF_CLKSEL);
    assign wrCompare[0] = wrDone && hitReg(paddr, 1'b0, timer_pwm_pkg::OFF_COMPARE);
    assign wrCompare[1] = wrDone && hitReg(paddr, 1'b1, timer_pwm_pkg::OFF_COMPARE);

    // ---------------------------------------------------------------
    // read mux
    // ---------------------------------------------------------------
    wire       rdCh     = paddr[4];
    wire [7:0] rdOff    = paddr & ~timer_pwm_pkg::CHAN_STRIDE;
    // set/reset bits always read back as zero
    wire [7:0] modeRead = modeControlReg_q[rdCh]
                        & ~(8'h01 << timer_pwm_pkg::MODE_SET_BIT)
                        & ~(8'h01 << timer_pwm_pkg::MODE_RESET_BIT);
    wire [7:0] rdByte   =
        (rdOff == timer_pwm_pkg::OFF_MODE)    ? modeRead :
        (rdOff == timer_pwm_pkg::OFF_CLKSEL)  ? {5'h00, countClockSelReg_q[rdCh]} :
        (rdOff == timer_pwm_pkg::OFF_COMPARE) ? compareValueReg_q[rdCh] :
        eightBitCounter_q[rdCh];

    // ---------------------------------------------------------------
    // mode decode
    // ---------------------------------------------------------------
    wire cascade = modeControlReg_q[1][timer_pwm_pkg::MODE_CASC_BIT];
    wire [1:0] pwmMode;
    wire [1:0] run;
    wire [1:0] presRun;
    wire [1:0] tick;
    wire [1:0] step;
    wire [1:0] clrMatch;
    wire [1:0] overflow;
    wire [1:0] pwmMatch;
    wire [1:0] level;
    wire       lowerWrap;
    wire       wideMatch;
    wire       upperIrqEvt;

    assign pwmMode[0] = modeControlReg_q[0][timer_pwm_pkg::MODE_PWM_BIT] && !cascade;
    assign pwmMode[1] = modeControlReg_q[1][timer_pwm_pkg::MODE_PWM_BIT] && !cascade;
    assign run[0]     = modeControlReg_q[0][timer_pwm_pkg::MODE_CE_BIT];
    // lower enable runs the joined pair
    assign run[1]     = cascade ? run[0]
                      : modeControlReg_q[1][timer_pwm_pkg::MODE_CE_BIT];
    assign presRun[0] = run[0];
    assign presRun[1] = run[1] && !cascade;
    assign level[0]   = modeControlReg_q[0][timer_pwm_pkg::MODE_LEVEL_BIT];
    assign level[1]   = modeControlReg_q[1][timer_pwm_pkg::MODE_LEVEL_BIT];

    // ---------------------------------------------------------------
    // prescalers
    // ---------------------------------------------------------------
    timer_prescaler presLower (
        .clk   (clk),
        .rst_n (rst_n),
        .run   (presRun[0]),
        .sel   (countClockSelReg_q[0]),
        .tick  (tick[0])
    );

    timer_prescaler presUpper (
        .clk   (clk),
        .rst_n (rst_n),
        .run   (presRun[1]),
        .sel   (countClockSelReg_q[1]),
        .tick  (tick[1])
    );

    // ---------------------------------------------------------------
    // counter events
    // ---------------------------------------------------------------
    assign lowerWrap = tick[0] && (eightBitCounter_q[0] == timer_pwm_pkg::CNT_MAX);
    assign wideMatch = cascade && tick[0]
                    && ({eightBitCounter_q[1], eightBitCounter_q[0]}
                        == {compareValueReg_q[1], compareValueReg_q[0]});
    assign step[0]   = tick[0];
    // upper ignores its own count rate when joined
    assign step[1]   = cascade ? lowerWrap : tick[1];

    assign clrMatch[0] = cascade ? wideMatch
                       : (!pwmMode[0] && step[0]
                          && (eightBitCounter_q[0] == compareActive_q[0]));
    assign clrMatch[1] = cascade ? wideMatch
                       : (!pwmMode[1] && step[1]
                          && (eightBitCounter_q[1] == compareActive_q[1]));
    // upper still flags its own byte match while joined
    assign upperIrqEvt = cascade
                       ? (tick[0] && (eightBitCounter_q[1] == compareValueReg_q[1])
                          && (eightBitCounter_q[0] == timer_pwm_pkg::CNT_ZERO))
                       : clrMatch[1];

    assign overflow[0] = pwmMode[0] && step[0]
                      && (eightBitCounter_q[0] == timer_pwm_pkg::CNT_MAX);
    assign overflow[1] = pwmMode[1] && step[1]
                      && (eightBitCounter_q[1] == timer_pwm_pkg::CNT_MAX);
    assign pwmMatch[0] = pwmMode[0] && step[0]
                      && (eightBitCounter_q[0] == compareActive_q[0]);
    assign pwmMatch[1] = pwmMode[1] && step[1]
                      && (eightBitCounter_q[1] == compareActive_q[1]);

    // ---------------------------------------------------------------
    // per-channel state
    // ---------------------------------------------------------------
    for (genvar i = 0; i < 2; i++) begin : g_chan
        wire [7:0] modeMask = (i == 0) ? timer_pwm_pkg::MODE_MASK_LOWER
                                       : timer_pwm_pkg::MODE_MASK_UPPER;
        wire       wrSet    = wrMode[i] && pwdata[timer_pwm_pkg::MODE_SET_BIT]
                           && !pwdata[timer_pwm_pkg::MODE_RESET_BIT];
        wire       wrClr    = wrMode[i] && pwdata[timer_pwm_pkg::MODE_RESET_BIT]
                           && !pwdata[timer_pwm_pkg::MODE_SET_BIT];
        // PWM pin level: active when phase flag set, polarity from level bit
        wire       pwmPin   = pwmLevel_q[i] ^ level[i];
        wire       pinVal   = pwmMode[i] ? pwmPin : outFlop_q[i];

        // counter clears on stop, on match outside PWM mode, else advances and wraps
        assign eightBitCounter_d[i] =
            !run[i]     ? timer_pwm_pkg::CNT_ZERO :
            clrMatch[i] ? timer_pwm_pkg::CNT_ZERO :
            step[i]     ? eightBitCounter_q[i] + 8'h01 :
            eightBitCounter_q[i];

        always_ff @(posedge clk) begin
            if (!rst_n) begin
                modeControlReg_q[i] <= timer_pwm_pkg::MODE_RESET_VAL;
            end else if (wrMode[i]) begin
                modeControlReg_q[i] <= pwdata[7:0] & modeMask;
            end
        end

        always_ff @(posedge clk) begin
            if (!rst_n) begin
                countClockSelReg_q[i] <= timer_pwm_pkg::CLKSEL_RESET;
                compareValueReg_q[i]  <= timer_pwm_pkg::COMPARE_RESET;
            end else begin
                if (wrClkSel[i]) begin
                    countClockSelReg_q[i] <= pwdata[timer_pwm_pkg::CLKSEL_W-1:0];
                end
                if (wrCompare[i]) begin
                    compareValueReg_q[i] <= pwdata[7:0];
                end
            end
        end

        // matching copy of compare, reloaded only at overflow while PWM runs
        always_ff @(posedge clk) begin
            if (!rst_n) begin
                compareActive_q[i] <= timer_pwm_pkg::COMPARE_RESET;
            end else if (!(run[i] && pwmMode[i]) || overflow[i]) begin
                compareActive_q[i] <= compareValueReg_q[i];
            end
        end

        always_ff @(posedge clk) begin
            if (!rst_n) begin
                eightBitCounter_q[i] <= timer_pwm_pkg::CNT_ZERO;
            end else begin
                eightBitCounter_q[i] <= eightBitCounter_d[i];
            end
        end

        // PWM phase: cleared at start, active from overflow to match
        always_ff @(posedge clk) begin
            if (!rst_n) begin
                pwmLevel_q[i] <= 1'b0;
            end else if (!run[i] || !pwmMode[i]) begin
                pwmLevel_q[i] <= 1'b0;
            end else if (overflow[i]) begin
                pwmLevel_q[i] <= 1'b1;
            end else if (pwmMatch[i]) begin
                pwmLevel_q[i] <= 1'b0;
            end
        end

        // output flip-flop: software set/clear wins over match inversion
        always_ff @(posedge clk) begin
            if (!rst_n) begin
                outFlop_q[i] <= 1'b0;
            end else if (wrSet) begin
                outFlop_q[i] <= 1'b1;
            end else if (wrClr) begin
                outFlop_q[i] <= 1'b0;
            end else if (!pwmMode[i] && clrMatch[i] && level[i]) begin
                outFlop_q[i] <= ~outFlop_q[i];
            end
        end

        always_ff @(posedge clk) begin
            if (!rst_n) begin
                pinOut_q[i] <= 1'b0;
                pinEn_q[i]  <= 1'b0;
            end else begin
                pinOut_q[i] <= modeControlReg_q[i][timer_pwm_pkg::MODE_OE_BIT]
                             && pinVal;
                pinEn_q[i]  <= modeControlReg_q[i][timer_pwm_pkg::MODE_OE_BIT];
            end
        end
    end

    // ---------------------------------------------------------------
    // match pulses
    // ---------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            lowerIrq_q <= 1'b0;
            upperIrq_q <= 1'b0;
        end else begin
            lowerIrq_q <= clrMatch[0];
            upperIrq_q <= upperIrqEvt;
        end
    end

    // ---------------------------------------------------------------
    // APB answer: one wait-free access phase, data latched at setup
    // ---------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= 32'h0000_0000;
        end else begin
            pready_q  <= setupPhase;
            pslverr_q <= setupPhase && !addrMapped;
            if (setupPhase) begin
                prdata_q <= (addrMapped && !pwrite) ? {24'h00_0000, rdByte}
                                                    : 32'h0000_0000;
            end
        end
    end

    assign prdata         = prdata_q;
    assign pready         = pready_q;
    assign pslverr        = pslverr_q;
    assign timerOutputPin = pinOut_q;
    assign timerOutputEn  = pinEn_q;
    assign lowerMatchIrq  = lowerIrq_q;
    assign upperMatchIrq  = upperIrq_q;
endmodule
`default_nettype wire

//--- verification/timer_pwm_cascade_chk.sv
// concurrent checks on the dual timer ports
`timescale 1ns/1ps
`default_nettype none
module timer_pwm_cascade_chk (
    input wire logic        clk,
    input wire logic        rst_n,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic [1:0]  timerOutputPin,
    input wire logic [1:0]  timerOutputEn,
    input wire logic        lowerMatchIrq,
    input wire logic        upperMatchIrq
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_mode0_wr;
        psel && penable && pready && pwrite && paddr == timer_pwm_pkg::OFF_MODE;
    endsequence
    property p_ready_next; s_setup |=> pready; endproperty
    a_ready_next: assert property (p_ready_next) else $error("no ready after setup");
    property p_ready_pulse; pready |=> !pready; endproperty
    a_ready_pulse: assert property (p_ready_pulse) else $error("ready held too long");
    property p_err_map;
        s_setup ##0 (paddr > timer_pwm_pkg::MAP_LAST || paddr[1:0] != 2'b00)
            |=> pslverr && prdata == 32'h0000_0000;
    endproperty
    a_err_map: assert property (p_err_map) else $error("unmapped access accepted");
    property p_rd_upper; pready |-> prdata[31:8] == 24'h00_0000; endproperty
    a_rd_upper: assert property (p_rd_upper) else $error("read data upper bits set");
    property p_pin_gated; (timerOutputPin & ~timerOutputEn) == 2'b00; endproperty
    a_pin_gated: assert property (p_pin_gated) else $error("pin driven in port mode");
    property p_oe_on; s_mode0_wr ##0 pwdata[0] |-> ##[1:2] timerOutputEn[0]; endproperty
    a_oe_on: assert property (p_oe_on) else $error("output enable not applied");
    property p_stop_level;
        s_mode0_wr ##0 (pwdata[7:6] == 2'b01 && pwdata[0])
            |-> ##3 timerOutputPin[0] == $past(pwdata[1], 3);
    endproperty
    a_stop_level: assert property (p_stop_level) else $error("stopped pwm not inactive");
    property p_lo_pulse; lowerMatchIrq |=> !lowerMatchIrq; endproperty
    a_lo_pulse: assert property (p_lo_pulse) else $error("lower match too long");
    property p_up_pulse; upperMatchIrq |=> !upperMatchIrq; endproperty
    a_up_pulse: assert property (p_up_pulse) else $error("upper match too long");
    property p_quiet; s_mode0_wr ##0 !pwdata[7] |-> ##2 !lowerMatchIrq [*8]; endproperty
    a_quiet: assert property (p_quiet) else $error("match while stopped");
endmodule
bind timer_pwm_cascade timer_pwm_cascade_chk u_timer_pwm_cascade_chk (.clk, .rst_n, .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .timerOutputPin,
    .timerOutputEn, .lowerMatchIrq, .upperMatchIrq);
`default_nettype wire

//--- verification/timer_pin_load.sv
// pin load on the timer outputs; times the high runs of channel 0
`timescale 1ns/1ps
`default_nettype none
module timer_pin_load (
    input  wire logic       clk,
    input  wire logic [1:0] timerOutputPin,
    input  wire logic [1:0] timerOutputEn,
    output logic [1:0]      padLevel,
    output int              highLen,
    output int              falls
);
    int run = 0;
    // a pad left in port mode is pulled low
    assign padLevel = timerOutputPin & timerOutputEn;
    // int outputs start at zero, so the counting process is their only driver
    always @(posedge clk) begin
        if (padLevel[0] === 1'b1) begin
            run <= run + 1;
        end else if (run != 0) begin
            highLen <= run;
            falls <= falls + 1;
            run <= 0;
        end
    end
endmodule
`default_nettype wire

//--- verification/timer_pwm_cascade_tb_top.sv
// self-checking bench for the dual timer block
`timescale 1ns/1ps
`default_nettype none
module timer_pwm_cascade_tb_top;
    localparam logic [7:0] MD0 = 8'h00, CS0 = 8'h04, CP0 = 8'h08, CT0 = 8'h0C;
    localparam logic [7:0] MD1 = 8'h10, CS1 = 8'h14, CP1 = 8'h18;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata, r;
    logic [1:0]  timerOutputPin, timerOutputEn, padLevel;
    logic        pready, pslverr, lowerMatchIrq, upperMatchIrq, e;
    int          highLen, falls, c, m, n, f, g, q[$];
    int          miscompares = 0, num_checks = 0, cyc = 0, seed = 98;
    always #50 clk = ~clk;
    timer_pwm_cascade u_timer_pwm_cascade (.clk, .rst_n, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .timerOutputPin, .timerOutputEn,
        .lowerMatchIrq, .upperMatchIrq);
    timer_pin_load u_timer_pin_load (.clk, .timerOutputPin, .timerOutputEn, .padLevel,
        .highLen, .falls);
    task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp, input string w);
        num_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected at %0t: %s", $time, w);
        end
    endtask
    task automatic chk_int(input int got, input int lo, input int hi, input string w);
        num_checks++;
        if (got < lo || got > hi) begin
            miscompares++;
            $display("unexpected at %0t: %s %0d", $time, w, got);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        {psel, penable} <= 2'b00;
    endtask
    // f: cycles to the next pulse, g: cycles from that pulse to the one after
    task automatic gap(input logic up, output int f, output int g);
        f = 0;
        g = 0;
        while ((up ? upperMatchIrq : lowerMatchIrq) !== 1'b1) begin
            @(posedge clk);
            f++;
        end
        do begin
            @(posedge clk);
            g++;
        end while ((up ? upperMatchIrq : lowerMatchIrq) !== 1'b1);
    endtask
    task automatic next_high(output int h);
        int f0;
        f0 = falls;
        wait (falls != f0);
        h = highLen;
    endtask
    task automatic report_and_stop();
        $display("checks %0d, mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            miscompares++;
            $display("unexpected at %0t: timeout", $time);
            report_and_stop();
        end
    end
    // ---------------------------------------------------------------
    // main sequence
    // ---------------------------------------------------------------
    initial begin
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        for (int i = 0; i < 32; i += 4) begin
            apb(1'b0, 8'(i), 32'h0000_0000);
            chk_reg(r, 32'h0000_0000, "reset value");
        end
        apb(1'b0, 8'h20, 32'h0000_0000);
        chk_reg({r[30:0], e}, 32'h0000_0001, "unmapped read");
        for (int v = 0; v < 256; v += 255) begin
            apb(1'b1, CP1, 32'(v));
            apb(1'b0, CP1, 32'h0000_0000);
            chk_reg(r, 32'(v), "compare range");
        end
        n = 8'h10 + ($random(seed) & 8'h1F);
        apb(1'b1, CS0, 32'h0000_0001);
        apb(1'b1, CP0, 32'(n));
        apb(1'b1, MD0, 32'h0000_0080);
        gap(1'b0, f, g);
        chk_int(g, (n + 1) * 16, (n + 1) * 16, "interval");
        apb(1'b1, CP0, 32'h0000_0040);
        repeat (768) @(posedge clk);
        apb(1'b1, CP0, 32'h0000_0008);
        gap(1'b0, f, g);
        chk_int(f, 3420, 3500, "wrap before match");
        apb(1'b1, MD0, 32'h0000_0000);
        apb(1'b0, CT0, 32'h0000_0000);
        chk_reg(r, 32'h0000_0000, "count cleared");
        apb(1'b1, MD0, 32'h0000_0009);
        repeat (3) @(posedge clk);
        chk_reg(32'(padLevel[0]), 32'h0000_0001, "output set");
        apb(1'b0, MD0, 32'h0000_0000);
        chk_reg(r, 32'h0000_0001, "set bits read zero");
        apb(1'b1, MD0, 32'h0000_0005);
        repeat (3) @(posedge clk);
        chk_reg(32'(padLevel[0]), 32'h0000_0000, "output reset");
        c = 8'h40 + ($random(seed) & 8'h3F);
        m = 8'h08 + ($random(seed) & 8'h1F);
        apb(1'b1, CS0, 32'h0000_0000);
        apb(1'b1, CP0, 32'(c));
        // clear mode with inversion: output flop toggles on every match
        apb(1'b1, MD0, 32'h0000_0083);
        next_high(g);
        next_high(g);
        chk_int(g, (c + 1) * 8, (c + 1) * 8, "square wave");
        apb(1'b1, MD0, 32'h0000_0000);
        apb(1'b1, MD0, 32'h0000_00C1);
        f = 0;
        while (padLevel[0] !== 1'b1) begin
            @(posedge clk);
            f++;
        end
        chk_int(f, 2040, 2056, "first overflow");
        apb(1'b1, CP0, 32'(m));
        q = '{c, m};
        repeat (2) begin
            next_high(g);
            n = q.pop_front();
            chk_int(g, (n + 1) * 8, (n + 1) * 8, "active width");
        end
        apb(1'b1, MD0, 32'h0000_00C3);
        next_high(g);
        next_high(g);
        chk_int(g, 2048 - (m + 1) * 8, 2048 - (m + 1) * 8, "inactive width");
        apb(1'b1, MD0, 32'h0000_0043);
        repeat (4) @(posedge clk);
        chk_reg(32'(padLevel[0]), 32'h0000_0001, "stopped level");
        apb(1'b1, MD0, 32'h0000_0002);
        repeat (3) @(posedge clk);
        chk_reg(32'(timerOutputEn), 32'h0000_0000, "port mode");
        c = $random(seed) & 8'h0F;
        apb(1'b1, CP0, 32'(c));
        apb(1'b1, CP1, 32'h0000_0001);
        apb(1'b1, CS1, 32'h0000_0007);
        apb(1'b1, MD1, 32'h0000_0010);
        apb(1'b1, MD1, 32'h0000_0090);
        apb(1'b1, MD0, 32'h0000_0080);
        gap(1'b0, f, g);
        chk_int(g, (257 + c) * 8, (257 + c) * 8, "cascade");
        gap(1'b1, f, g);
        chk_int(g, (257 + c) * 8, (257 + c) * 8, "upper match");
        apb(1'b1, MD0, 32'h0000_0000);
        n = 0;
        repeat (2200) begin
            @(posedge clk);
            n += (lowerMatchIrq !== 1'b0);
        end
        chk_int(n, 0, 0, "cascade stopped");
        report_and_stop();
    end
endmodule
`default_nettype wire
